// ---- rtl/parallel_port_pin_mux.sv ----
// Purpose: 16-pin parallel port with function select and pin mux
// Assumes: pins and host strobes synchronous to clock
// Notes: register reads answer one cycle after the read strobe
// =====================================================================
// Summary of operation
// - function select bit clear means general I/O, set means dedicated peripheral
// - function select loads f000 with strap high, f001 otherwise, at reset
// - direction clears at reset; 0 input, 1 output for general pins
// - with strap low, pin 0 drives eeprom select low within 3 clocks
// - data writes always load latch; reads give latch, pin, or peripheral state
// - unused peripheral inputs are tied to fixed levels per pin function
// - pins 1-3 general with slave enable act as slave selects from latch
// - eeprom access asserts its select when function bit 0 is set and negates enabled slave selects
// - after the eeprom access slave selects return to their latch level
// - negate level bits 7,6,5 serve selects 3,2,1; 1 negates high
// - slave enable acts only while the pin is a general output
// - alternate select bits 7-15 choose functions only when function bit set
// - alternate bit picks interrupt input or second function for pins 7-10 and 12-15
// - alternate bits 0-6 steer non-port host pins; bit 6 reserved
// - pin 8 strobe function becomes frame sync when codec choice is set
// - in card mode ready versus interrupt request follows card option bit
// - an interrupt mapped on two pins asserts on either pin
// - 8-bit ISA mode outside card mode turns data pins 10-8 into interrupt outputs
`timescale 1ns/1ns
module parallel_port_pin_mux import port_mux_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic eepromPresentStrap,
  input wire logic cardMode,
  input wire logic isa8BitMode,
  input wire logic cardOptionReadySel,
  input wire logic codecStrobeChoice,
  input wire logic eepromAccess,
  input wire logic bootLoadDone,
  input wire logic [11:0] regAddr,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [15:0] regWdata,
  output logic [15:0] regRdata,
  input wire logic [15:0] portPinIn,
  input wire logic [15:0] periphOut,
  input wire logic [15:0] periphOe,
  input wire logic frameSyncOut,
  input wire logic a19PinIn,
  input wire logic [2:0] intOutLines,
  output logic [15:0] portPinOut,
  output logic [15:0] portPinOe,
  output logic eepromSelectN,
  output logic [5:0] extIntN,
  output logic receiveClock,
  output logic ringIndicateN,
  output logic [4:0] addrHighBits,
  output logic serialRxd,
  output logic [5:0] hostPinSelect,
  output logic [2:0] dataPinIntOut,
  output logic [2:0] dataPinIntOe
);
  // =====================================================================
  // registers and internal nets
  logic [15:0] fsel_q;
  logic [15:0] dir_q;
  logic [15:0] latch_q;
  logic [15:0] alt_q;
  logic [7:0] ssc_q;
  boot_state_t boot_q;
  logic eepromActive;
  logic [15:0] readData_d;
  logic [15:0] gpioRead;
  logic [15:0] dedRead;
  logic [5:0] intN_d;
  logic rxClk_d;
  logic ring_d;
  logic [4:0] addr_d;
  logic rxd_d;
  logic wrFsel;
  logic wrDir;
  logic wrLatch;
  logic wrAlt;
  logic wrSsc;

  port_cfg_if cfg ();

  assign wrFsel = regWr && (regAddr == FSEL_ADDR);
  assign wrDir = regWr && (regAddr == DIR_ADDR);
  assign wrLatch = regWr && (regAddr == LATCH_ADDR);
  assign wrAlt = regWr && (regAddr == ALT_ADDR);
  assign wrSsc = regWr && (regAddr == SSC_ADDR);

  // =====================================================================
  // boot sequencing: strap caught on the first edge after release
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      boot_q <= BOOT_RESET;
    end else begin
      case (boot_q)
        BOOT_RESET: begin
          boot_q <= eepromPresentStrap ? BOOT_IDLE : BOOT_LOAD;
        end
        BOOT_LOAD: begin
          if (bootLoadDone) begin
            boot_q <= BOOT_IDLE;
          end
        end
        BOOT_IDLE: begin
          boot_q <= BOOT_IDLE;
        end
        default: begin
          boot_q <= BOOT_IDLE;
        end
      endcase
    end
  end

  assign eepromActive = (boot_q == BOOT_LOAD) || eepromAccess;

  // =====================================================================
  // function select register
  // async reset cannot see the strap, so it is applied one edge later
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      fsel_q <= FSEL_RESET_NO_STRAP;
    end else if (boot_q == BOOT_RESET) begin
      fsel_q <= eepromPresentStrap ? FSEL_RESET_STRAP : FSEL_RESET_NO_STRAP;
    end else if (wrFsel) begin
      fsel_q <= regWdata;
    end
  end

  // =====================================================================
  // direction, data latch, alternate select, slave select control
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dir_q <= DIR_RESET;
    end else if (wrDir) begin
      dir_q <= regWdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_q <= LATCH_RESET;
    end else if (wrLatch) begin
      latch_q <= regWdata;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      alt_q <= ALT_RESET;
    end else if (wrAlt) begin
      alt_q <= regWdata & ALT_WRITE_MASK;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ssc_q <= SSC_RESET;
    end else if (wrSsc) begin
      ssc_q <= regWdata[7:0] & SSC_WRITE_MASK;
    end
  end

  // =====================================================================
  // pin configuration bundle
  assign cfg.fsel = fsel_q;
  assign cfg.dir = dir_q;
  assign cfg.latch = latch_q;
  assign cfg.alt = alt_q;
  assign cfg.pinIn = portPinIn;
  assign cfg.periphOut = periphOut;
  assign cfg.periphOe = periphOe;
  assign cfg.negLevel = ssc_q[NEG_LSB +: 3];
  assign cfg.slvEn = ssc_q[SLV_LSB +: 3];
  assign cfg.eepromActive = eepromActive;
  assign cfg.codecStrobeChoice = codecStrobeChoice;
  assign cfg.frameSync = frameSyncOut;

  pin_output_mux u_out (
    .cfg(cfg.mux)
  );

  peripheral_input_tie u_tie (
    .cfg(cfg.tie),
    .a19PinIn(a19PinIn),
    .extIntN(intN_d),
    .receiveClock(rxClk_d),
    .ringN(ring_d),
    .addrHigh(addr_d),
    .serialRxd(rxd_d)
  );

  // =====================================================================
  // pin drivers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      portPinOut <= 16'h0000;
      portPinOe <= 16'h0000;
      eepromSelectN <= 1'b1;
    end else begin
      portPinOut <= cfg.muxOut;
      portPinOe <= cfg.muxOe;
      eepromSelectN <= ~(fsel_q[0] && eepromActive);
    end
  end

  // =====================================================================
  // peripheral inputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      extIntN <= 6'h3f;
      receiveClock <= 1'b0;
      ringIndicateN <= 1'b1;
      addrHighBits <= 5'h00;
      serialRxd <= 1'b1;
    end else begin
      extIntN <= intN_d;
      receiveClock <= rxClk_d;
      ringIndicateN <= ring_d;
      addrHighBits <= addr_d;
      serialRxd <= rxd_d;
    end
  end

  // =====================================================================
  // host pin selects and 8-bit interrupt outputs
  // data pin reuse is locked out in card mode whatever the width strap says
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hostPinSelect <= 6'h00;
      dataPinIntOut <= 3'h0;
      dataPinIntOe <= 3'h0;
    end else begin
      hostPinSelect[0] <= alt_q[0];
      hostPinSelect[1] <= cardMode ? cardOptionReadySel : alt_q[1];
      hostPinSelect[5:2] <= alt_q[5:2];
      dataPinIntOut <= intOutLines;
      dataPinIntOe <= {3{isa8BitMode && !cardMode}};
    end
  end

  // =====================================================================
  // register read path
  assign gpioRead = (dir_q & latch_q) | (~dir_q & portPinIn);
  assign dedRead = (cfg.muxOe & cfg.muxOut) | (~cfg.muxOe & portPinIn);

  always_comb begin
    case (regAddr)
      FSEL_ADDR: readData_d = fsel_q;
      DIR_ADDR: readData_d = dir_q;
      LATCH_ADDR: readData_d = (fsel_q & dedRead) | (~fsel_q & gpioRead);
      ALT_ADDR: readData_d = alt_q;
      SSC_ADDR: readData_d = {8'h00, ssc_q};
      default: readData_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      regRdata <= readData_d;
    end
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence releaseSeq;
    $fell(rst);
  endsequence

  sequence eepromSelDriven;
    (portPinOe[0] && !portPinOut[0] && !eepromSelectN);
  endsequence

  sequence accessWindow;
    eepromAccess && fsel_q[1] == 1'b0 && dir_q[1] && ssc_q[1];
  endsequence

  AST_STRAP_LOAD: assert property (releaseSeq ##0 !$past(eepromPresentStrap) |=>
    fsel_q == FSEL_RESET_NO_STRAP)
    else $error("function select not loaded from strap");

  AST_STRAP_HIGH: assert property (boot_q == BOOT_RESET && eepromPresentStrap |=>
    fsel_q == FSEL_RESET_STRAP)
    else $error("function select not f000 with strap high");

  AST_EEPROM_SELECT: assert property (boot_q == BOOT_RESET && !eepromPresentStrap |->
    ##[1:3] eepromSelDriven)
    else $error("eeprom select not driven low in time");

  AST_DIR_RESET: assert property (releaseSeq |->
    dir_q == DIR_RESET && portPinOe[15:1] == 15'h0)
    else $error("direction not cleared after reset");

  AST_LATCH_WRITE: assert property (wrLatch |=> latch_q == $past(regWdata))
    else $error("data write did not reach latch");

  AST_SLAVE_NEGATE: assert property (accessWindow |=> portPinOut[1] == $past(ssc_q[5]))
    else $error("slave select not negated during eeprom access");

  AST_SLAVE_RETURN: assert property (
    (!eepromActive && !fsel_q[2] && dir_q[2]) [*2] |-> portPinOut[2] == $past(latch_q[2]))
    else $error("slave select did not return to latch level");

  AST_INPUT_NO_DRIVE: assert property (!fsel_q[3] && !dir_q[3] |=> !portPinOe[3])
    else $error("general input pin driven");

  AST_CARD_READY: assert property (cardMode |=>
    hostPinSelect[1] == $past(cardOptionReadySel))
    else $error("card ready select not from card option bit");

  AST_DATA_INT: assert property (cardMode |=> dataPinIntOe == 3'h0)
    else $error("data pin interrupt enabled in card mode");

  AST_INT_OR: assert property (fsel_q[12] && !alt_q[12] && !portPinIn[12] |=>
    !extIntN[1])
    else $error("second pin did not raise interrupt two");

  AST_RSVD_ZERO: assert property (regRd && regAddr == SSC_ADDR |=>
    regRdata[4] == 1'b0 && regRdata[0] == 1'b0 && regRdata[15:8] == 8'h00)
    else $error("reserved control bits not zero");

  AST_DATA_INT_ON: assert property (isa8BitMode && !cardMode |=>
    dataPinIntOe == 3'h7 && dataPinIntOut == $past(intOutLines))
    else $error("data pin interrupts not enabled in 8-bit mode");

  AST_FRAME_SYNC: assert property (
    fsel_q[8] && alt_q[8] && periphOe[8] && codecStrobeChoice |=>
    portPinOe[8] && portPinOut[8] == $past(frameSyncOut))
    else $error("pin 8 strobe not replaced by frame sync");

  AST_GPIO_OUT: assert property (!fsel_q[5] |=>
    portPinOe[5] == $past(dir_q[5]) && portPinOut[5] == $past(latch_q[5]))
    else $error("general pin not driven from direction and latch");

  AST_FIXED_RING: assert property (!fsel_q[10] |=> ringIndicateN)
    else $error("ring indicate input not tied inactive");

  AST_ALT_RSVD: assert property (regRd && regAddr == ALT_ADDR |=> !regRdata[6])
    else $error("reserved alternate select bit not zero");
endmodule : parallel_port_pin_mux

// ---- rtl/peripheral_input_tie.sv ----
// Purpose: routes pin levels to peripheral inputs or fixed levels
// Assumes: interrupt inputs are active low
// Notes: a duplicated interrupt asserts when either pin asserts
`timescale 1ns/1ns
module peripheral_input_tie import port_mux_pkg::*; (
  port_cfg_if.tie cfg,
  input wire logic a19PinIn,
  output logic [5:0] extIntN,
  output logic receiveClock,
  output logic ringN,
  output logic [4:0] addrHigh,
  output logic serialRxd
);
  logic [15:0] selInt;
  logic [15:0] selAlt;
  logic [15:0] p;
  assign selInt = cfg.fsel & ~cfg.alt;
  assign selAlt = cfg.fsel & cfg.alt;
  assign p = cfg.pinIn;
  // =====================================================================
  // interrupt inputs, unused sources tied inactive high
  assign extIntN[0] = (selInt[7] ? p[7] : 1'b1) & (cfg.alt[0] ? a19PinIn : 1'b1);
  assign extIntN[1] = (selInt[8] ? p[8] : 1'b1) & (selInt[12] ? p[12] : 1'b1);
  assign extIntN[2] = (selInt[9] ? p[9] : 1'b1) & (selInt[13] ? p[13] : 1'b1);
  assign extIntN[3] = (selInt[10] ? p[10] : 1'b1) & (selInt[14] ? p[14] : 1'b1);
  assign extIntN[4] = (cfg.fsel[1] ? p[1] : 1'b1) & (selInt[15] ? p[15] : 1'b1);
  assign extIntN[5] = cfg.fsel[2] ? p[2] : 1'b1;
  // =====================================================================
  // other peripheral inputs with their fixed levels
  assign receiveClock = selAlt[7] ? p[7] : 1'b0;
  assign ringN = selAlt[10] ? p[10] : 1'b1;
  assign addrHigh[4:1] = selAlt[15:12] & p[15:12];
  assign addrHigh[0] = cfg.alt[0] ? 1'b0 : a19PinIn;
  assign serialRxd = cfg.fsel[4] ? p[4] : 1'b1;
endmodule : peripheral_input_tie

// ---- rtl/pin_output_mux.sv ----
// Purpose: per-pin output value and enable selection
// Assumes: configuration arrives over port_cfg_if
// Notes: purely combinational, registered by the top
`timescale 1ns/1ns
module pin_output_mux import port_mux_pkg::*; (
  port_cfg_if.mux cfg
);
  logic [15:0] gpioOut;
  logic [15:0] dedOut;
  logic [15:0] dedOe;
  for (genvar i = 0; i < 16; i++) begin : g_pin
    // =====================================================================
    // general purpose value, with auto negation on slave selects
    if (i >= 1 && i <= 3) begin : g_ss
      assign gpioOut[i] = (cfg.slvEn[i-1] && cfg.dir[i] && cfg.eepromActive) ?
        cfg.negLevel[i-1] : cfg.latch[i];
    end else begin : g_plain
      assign gpioOut[i] = cfg.latch[i];
    end
    // =====================================================================
    // dedicated value
    if (i == 0) begin : g_eeprom
      assign dedOut[i] = ~cfg.eepromActive;
      assign dedOe[i] = 1'b1;
    end else if (i == 8) begin : g_strobe
      assign dedOut[i] = cfg.codecStrobeChoice ? cfg.frameSync : cfg.periphOut[i];
      assign dedOe[i] = cfg.periphOe[i] & cfg.alt[i];
    end else begin : g_periph
      assign dedOut[i] = cfg.periphOut[i];
      // interrupt inputs chosen by alternate select 0 never drive the pin
      assign dedOe[i] = cfg.periphOe[i] & (cfg.alt[i] | ~ALT_INPUT_PINS[i]);
    end
    assign cfg.muxOut[i] = cfg.fsel[i] ? dedOut[i] : gpioOut[i];
    assign cfg.muxOe[i] = cfg.fsel[i] ? dedOe[i] : cfg.dir[i];
  end
endmodule : pin_output_mux

// ---- rtl/port_cfg_if.sv ----
// Purpose: carries pin configuration between the port modules
// Assumes: driven by parallel_port_pin_mux, except muxOut and muxOe from pin_output_mux
// Notes: combinational bundle, no clocking
`timescale 1ns/1ns
interface port_cfg_if;
  logic [15:0] fsel;
  logic [15:0] dir;
  logic [15:0] latch;
  logic [15:0] alt;
  logic [15:0] pinIn;
  logic [15:0] periphOut;
  logic [15:0] periphOe;
  logic [2:0] negLevel;
  logic [2:0] slvEn;
  logic eepromActive;
  logic codecStrobeChoice;
  logic frameSync;
  logic [15:0] muxOut;
  logic [15:0] muxOe;
  modport mux (input fsel, dir, latch, alt, periphOut, periphOe, negLevel, slvEn,
    eepromActive, codecStrobeChoice, frameSync, output muxOut, muxOe);
  modport tie (input fsel, alt, pinIn);
endinterface : port_cfg_if

// ---- rtl/port_mux_pkg.sv ----
// Purpose: shared constants and types for the parallel port pin mux
// Assumes: 16 port pins, 16-bit host register data
// Notes: offsets are the host bus addresses of the port registers
package port_mux_pkg;
  // =====================================================================
  // register offsets
  localparam logic [11:0] FSEL_ADDR = 12'h81e;
  localparam logic [11:0] DIR_ADDR = 12'h820;
  localparam logic [11:0] LATCH_ADDR = 12'h822;
  localparam logic [11:0] ALT_ADDR = 12'h824;
  localparam logic [11:0] SSC_ADDR = 12'h826;
  // =====================================================================
  // values after reset and write masks
  localparam logic [15:0] FSEL_RESET_NO_STRAP = 16'hf001;
  localparam logic [15:0] FSEL_RESET_STRAP = 16'hf000;
  localparam logic [15:0] DIR_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] ALT_RESET = 16'hf000;
  localparam logic [15:0] ALT_WRITE_MASK = 16'hffbf;
  localparam logic [7:0] SSC_RESET = 8'h00;
  localparam logic [7:0] SSC_WRITE_MASK = 8'hee;
  // =====================================================================
  // field positions of the slave select control register
  localparam int NEG_LSB = 5;
  localparam int SLV_LSB = 1;
  // =====================================================================
  // pins whose alternate select 0 makes them interrupt inputs
  localparam logic [15:0] ALT_INPUT_PINS = 16'hf780;
  // select drive must appear within this many clocks of reset release
  localparam int EEPROM_SELECT_CLOCKS = 3;
  // =====================================================================
  // boot sequencing
  typedef enum logic [2:0] {
    BOOT_RESET = 3'b001,
    BOOT_LOAD = 3'b010,
    BOOT_IDLE = 3'b100
  } boot_state_t;
endpackage : port_mux_pkg

// ---- sim/parallel_port_pin_mux_tb.sv ----
// Purpose: self-checking bench for the parallel port pin mux
// Assumes: register reads answer one cycle after the strobe
// Notes: pins resolved through pin_partner; inputs move 1 ns after the edge
`timescale 1ns/1ns
module parallel_port_pin_mux_tb;
  import port_mux_pkg::*;
  logic clock, rst, eepromPresentStrap, cardMode, isa8BitMode, cardOptionReadySel;
  logic codecStrobeChoice, eepromAccess, bootLoadDone, regWr, regRd, frameSyncOut, a19PinIn;
  logic [11:0] regAddr;
  logic [15:0] regWdata, regRdata, portPinIn, periphOut, periphOe, portPinOut, portPinOe;
  logic [15:0] extLevel, extDrive;
  logic [2:0] intOutLines, dataPinIntOut, dataPinIntOe;
  logic eepromSelectN, receiveClock, ringIndicateN, serialRxd;
  logic [5:0] extIntN, hostPinSelect;
  logic [4:0] addrHighBits;
  int fails = 0;
  int numChecks = 0;
  int n;

  parallel_port_pin_mux dut (.clock, .rst, .eepromPresentStrap, .cardMode, .isa8BitMode,
    .cardOptionReadySel, .codecStrobeChoice, .eepromAccess, .bootLoadDone, .regAddr, .regWr,
    .regRd, .regWdata, .regRdata, .portPinIn, .periphOut, .periphOe, .frameSyncOut,
    .a19PinIn, .intOutLines, .portPinOut, .portPinOe, .eepromSelectN, .extIntN,
    .receiveClock, .ringIndicateN, .addrHighBits, .serialRxd, .hostPinSelect,
    .dataPinIntOut, .dataPinIntOe);

  pin_partner far (.portPinOut, .portPinOe, .extLevel, .extDrive, .portPinIn);

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // =====================================================================
  // shared tasks
  task automatic complete_run;
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one write per call; a free cycle follows so strobes never collide
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    regAddr = a;
    regWdata = d;
    regWr = 1'b1;
    @(posedge clock);
    #1 regWr = 1'b0;
    @(posedge clock);
    #1;
  endtask : wr

  task automatic rdchk(input logic [11:0] a, input logic [15:0] mask, input logic [15:0] exp);
    regAddr = a;
    regRd = 1'b1;
    @(posedge clock);
    #1 regRd = 1'b0;
    @(posedge clock);
    #1 chk(regRdata & mask, exp);
  endtask : rdchk

  // outputs are registered behind registered config: three edges cover it
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle

  task automatic do_reset(input logic strap);
    rst = 1'b1;
    eepromPresentStrap = strap;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
  endtask : do_reset

  // =====================================================================
  // watchdog, sized well above the 130 or so cycles the tests take
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end

  // =====================================================================
  // main sequence
  initial begin
    rst = 1'b1; eepromPresentStrap = 1'b0; cardMode = 1'b0; isa8BitMode = 1'b0;
    cardOptionReadySel = 1'b0; codecStrobeChoice = 1'b0; eepromAccess = 1'b0;
    bootLoadDone = 1'b0; regWr = 1'b0; regRd = 1'b0; frameSyncOut = 1'b0; a19PinIn = 1'b0;
    regAddr = 12'h000; regWdata = 16'h0000; periphOut = 16'h0000; periphOe = 16'h0000;
    extLevel = 16'hffff; extDrive = 16'h0000; intOutLines = 3'h0;
    // =====================================================================
    // reset without strap: eeprom select must show within three edges
    do_reset(1'b0);
    for (n = 0; n < 3; n++) begin
      @(posedge clock);
      #1;
      if (eepromSelectN === 1'b0 && portPinOe[0] === 1'b1 && portPinOut[0] === 1'b0) break;
    end
    chk({eepromSelectN, portPinOe[0], portPinOut[0]}, 16'h0002);
    rdchk(FSEL_ADDR, 16'hffff, 16'hf001);
    rdchk(DIR_ADDR, 16'hffff, 16'h0000);
    bootLoadDone = 1'b1;
    @(posedge clock);
    #1 bootLoadDone = 1'b0;
    // =====================================================================
    // reset with strap high
    do_reset(1'b1);
    settle();
    rdchk(FSEL_ADDR, 16'hffff, 16'hf000);
    // =====================================================================
    // general I/O: outputs from latch, inputs read as pins
    wr(FSEL_ADDR, 16'h0000);
    wr(DIR_ADDR, 16'h00ff);
    wr(LATCH_ADDR, 16'ha5c3);
    extDrive = 16'hff00;
    extLevel = 16'h3c00;
    settle();
    chk(portPinOe, 16'h00ff);
    chk(portPinOut & 16'h00ff, 16'h00c3);
    rdchk(LATCH_ADDR, 16'hffff, 16'h3cc3);
    // dedicated pins read back the peripheral or pin state
    wr(FSEL_ADDR, 16'h0030);
    periphOe = 16'h0020;
    periphOut = 16'h0020;
    extDrive = 16'hff10;
    settle();
    rdchk(LATCH_ADDR, 16'h0030, 16'h0020);
    periphOe = 16'h0000;
    // =====================================================================
    // slave selects: negate during eeprom access, restore afterwards
    wr(FSEL_ADDR, 16'h0001);
    wr(DIR_ADDR, 16'h000e);
    wr(SSC_ADDR, 16'h00ae);
    wr(LATCH_ADDR, 16'h0004);
    settle();
    chk(portPinOut & 16'h000e, 16'h0004);
    eepromAccess = 1'b1;
    settle();
    chk(portPinOut & 16'h000e, 16'h000a);
    chk(eepromSelectN, 16'h0000);
    eepromAccess = 1'b0;
    settle();
    chk(portPinOut & 16'h000e, 16'h0004);
    // pin 1 without enable, pin 3 as input: no negation on either
    wr(SSC_ADDR, 16'h00ac);
    wr(DIR_ADDR, 16'h0006);
    eepromAccess = 1'b1;
    settle();
    chk({portPinOut[3:1], portPinOe[3]}, 16'h0000);
    eepromAccess = 1'b0;
    // =====================================================================
    // register masks and unmapped place
    wr(SSC_ADDR, 16'h00ff);
    rdchk(SSC_ADDR, 16'hffff, 16'h00ee);
    wr(ALT_ADDR, 16'hffff);
    rdchk(ALT_ADDR, 16'hffff, 16'hffbf);
    rdchk(12'h830, 16'hffff, 16'h0000);
    rdchk(DIR_ADDR, 16'hffff, 16'h0006);
    // =====================================================================
    // interrupt inputs on pins, duplicated inputs ORed
    wr(FSEL_ADDR, 16'hff86);
    wr(ALT_ADDR, 16'h0000);
    extDrive = 16'hffff;
    extLevel = 16'hef7b;
    settle();
    chk(extIntN[1:0], 16'h0000);
    chk(extIntN[5:4], 16'h0001);
    extLevel = 16'hfeff;
    settle();
    chk(extIntN[1:0], 16'h0001);
    extLevel = 16'hffff;
    settle();
    chk(extIntN[1:0], 16'h0003);
    // general pins leave peripheral inputs at their fixed levels
    wr(FSEL_ADDR, 16'h0000);
    extLevel = 16'h0000;
    settle();
    chk({extIntN[4:0], ringIndicateN, receiveClock, serialRxd, addrHighBits[4:1]},
      16'h0fd0);
    // second dedicated functions
    wr(FSEL_ADDR, 16'hf780);
    wr(ALT_ADDR, 16'hf780);
    extLevel = 16'ha080;
    a19PinIn = 1'b1;
    settle();
    chk({receiveClock, ringIndicateN, extIntN[3:0]}, 16'h002f);
    chk(addrHighBits, 16'h0015);
    // host pin choices, card mode ready selection from option bit
    wr(ALT_ADDR, 16'hf7bf);
    a19PinIn = 1'b0;
    settle();
    chk(hostPinSelect, 16'h003f);
    chk(extIntN[0], 16'h0000);
    cardMode = 1'b1;
    settle();
    chk(hostPinSelect, 16'h003d);
    cardOptionReadySel = 1'b1;
    settle();
    chk(hostPinSelect, 16'h003f);
    cardMode = 1'b0;
    // =====================================================================
    // pin 8 strobe versus codec frame sync
    wr(FSEL_ADDR, 16'h0100);
    wr(ALT_ADDR, 16'h0100);
    periphOe = 16'h0100;
    periphOut = 16'h0000;
    frameSyncOut = 1'b1;
    codecStrobeChoice = 1'b1;
    settle();
    chk(portPinOut[8], 16'h0001);
    codecStrobeChoice = 1'b0;
    settle();
    chk(portPinOut[8], 16'h0000);
    // =====================================================================
    // 8-bit mode interrupt outputs on data pins, never in card mode
    isa8BitMode = 1'b1;
    intOutLines = 3'h5;
    settle();
    chk({dataPinIntOe, dataPinIntOut}, 16'h003d);
    cardMode = 1'b1;
    settle();
    chk(dataPinIntOe, 16'h0000);
    complete_run();
  end
endmodule : parallel_port_pin_mux_tb

// ---- sim/pin_partner.sv ----
// Purpose: external side of the port pins, a set of drivers with pull-ups
// Assumes: pin levels settle within the same cycle as the drive changes
// Notes: the device wins where it enables its driver
`timescale 1ns/1ns
module pin_partner (
  input wire logic [15:0] portPinOut,
  input wire logic [15:0] portPinOe,
  input wire logic [15:0] extLevel,
  input wire logic [15:0] extDrive,
  output logic [15:0] portPinIn
);
  // =====================================================================
  // pin resolution
  // undriven pins float to the pull-up, never to the last value
  always_comb begin
    portPinIn = (portPinOe & portPinOut) | (~portPinOe & extDrive & extLevel)
      | (~portPinOe & ~extDrive);
  end
endmodule : pin_partner
